// ### hw/rps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module rps_sequencer
  import rps_pkg::*;
#(
  parameter int unsigned MAINS_QUAL = MAINS_QUAL_CYC,
  parameter int unsigned ON_DELAY = ON_DELAY_CYC,
  parameter int unsigned CLAMP_DELAY = CLAMP_DELAY_CYC,
  parameter int unsigned FLAG_DELAY = FLAG_DELAY_CYC,
  parameter int unsigned RUN_OFF_DELAY = RUN_OFF_DELAY_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic mains_present,
  input wire logic p5v_present,
  input wire logic power_switch_on,
  input wire logic overcurrent,
  output logic supply_ok_flag_n,
  output logic system_run_line,
  output logic clamp_relay_on,
  output logic regulator_inhibit
);

  // Three-stage synchronisers; stage 0 feeds only stage 1.
  logic [2:0] sync0_q, sync0_d;
  logic [2:0] sync1_q, sync1_d;
  logic [2:0] sync2_q, sync2_d;
  // Accepted levels, updated when stages 1 and 2 agree.
  logic [2:0] level_q, level_d;
  // Mains dropout timer and qualified mains condition.
  logic [CNT_W-1:0] drop_cnt_q, drop_cnt_d;
  logic mains_ok_q, mains_ok_d;
  // Sequencer state, its delay counter and the outputs.
  rps_state_t state_q, state_d;
  logic [CNT_W-1:0] seq_cnt_q, seq_cnt_d;
  rps_out_t out_q, out_d;
  // Latched overcurrent fault.
  logic fault_q, fault_d;
  rps_cond_t cond;

  // Synchroniser next values; each pin passes three flops.
  always_comb begin
    sync0_d = {overcurrent, p5v_present, mains_present};
    sync1_d = sync0_q;
    sync2_d = sync1_q;
    level_d = level_q;
    for (int i = 0; i < 3; i++) begin
      if (sync1_q[i] == sync2_q[i]) begin
        level_d[i] = sync2_q[i];
      end
    end
  end

  // Synchroniser registers; reset clears them to the safe level.
  always_ff @(posedge clock) begin
    if (srst) begin
      sync0_q <= 3'h0;
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      level_q <= 3'h0;
    end else begin
      sync0_q <= sync0_d;
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      level_q <= level_d;
    end
  end

  // Mains qualification. A dropout only counts as a failure once it
  // has lasted longer than the qualify time; short glitches are ridden
  // through, which is the point of the timer.
  always_comb begin
    drop_cnt_d = drop_cnt_q;
    mains_ok_d = mains_ok_q;
    if (level_q[0]) begin
      // Mains present: restart the dropout timer at once.
      drop_cnt_d = '0;
      mains_ok_d = 1'b1;
    end else if (drop_cnt_q < CNT_W'(MAINS_QUAL)) begin
      drop_cnt_d = drop_cnt_q + CNT_W'(1);
    end else begin
      mains_ok_d = 1'b0;
    end
  end

  // Qualification registers.
  always_ff @(posedge clock) begin
    if (srst) begin
      drop_cnt_q <= '0;
      mains_ok_q <= 1'b0;
    end else begin
      drop_cnt_q <= drop_cnt_d;
      mains_ok_q <= mains_ok_d;
    end
  end

  // Conditions that allow the supply to be up; one driver for the struct.
  assign cond = '{mains_ok: mains_ok_q, p5v_ok: level_q[1],
                  switch_on: power_switch_on};

  // Overcurrent fault latch; only reset clears it.
  always_comb begin
    fault_d = fault_q | level_q[2];
  end

  // Fault register.
  always_ff @(posedge clock) begin
    if (srst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  // Sequencer. A single counter serves every delay, since the
  // delays never overlap except the clamp release, which is a
  // threshold inside the switch-on wait.
  always_comb begin
    logic down;
    down = !(cond.mains_ok && cond.p5v_ok && cond.switch_on);
    state_d = state_q;
    seq_cnt_d = seq_cnt_q;
    out_d = out_q;
    case (state_q)
      RPS_OFF: begin
        out_d = '{supply_ok_flag_n: 1'b0, system_run_line: 1'b0,
                  clamp_relay_on: 1'b0};
        seq_cnt_d = '0;
        if (!down) begin
          state_d = RPS_ON_WAIT;
        end
      end
      RPS_ON_WAIT: begin
        if (down) begin
          // Flag already low; run line low; go back quietly.
          state_d = RPS_OFF;
          out_d.clamp_relay_on = 1'b0;
          seq_cnt_d = '0;
        end else begin
          seq_cnt_d = seq_cnt_q + CNT_W'(1);
          if (seq_cnt_q + CNT_W'(1) >= CNT_W'(CLAMP_DELAY)) begin
            out_d.clamp_relay_on = 1'b1;
          end
          if (seq_cnt_q + CNT_W'(1) >= CNT_W'(ON_DELAY)) begin
            // Run line follows this delay, not the 2 ms timer.
            out_d.system_run_line = 1'b1;
            seq_cnt_d = '0;
            state_d = RPS_FLAG_WAIT;
          end
        end
      end
      RPS_FLAG_WAIT: begin
        if (down) begin
          out_d.supply_ok_flag_n = 1'b0;
          seq_cnt_d = '0;
          state_d = RPS_OFF_WAIT;
        end else begin
          seq_cnt_d = seq_cnt_q + CNT_W'(1);
          if (seq_cnt_q + CNT_W'(1) >= CNT_W'(FLAG_DELAY)) begin
            out_d.supply_ok_flag_n = 1'b1;
            state_d = RPS_RUNNING;
          end
        end
      end
      RPS_RUNNING: begin
        if (down) begin
          out_d.supply_ok_flag_n = 1'b0;
          seq_cnt_d = '0;
          state_d = RPS_OFF_WAIT;
        end
      end
      RPS_OFF_WAIT: begin
        // Conditions are ignored here so the sequence always ends.
        seq_cnt_d = seq_cnt_q + CNT_W'(1);
        if (seq_cnt_q + CNT_W'(1) >= CNT_W'(RUN_OFF_DELAY)) begin
          out_d.system_run_line = 1'b0;
          out_d.clamp_relay_on = 1'b0;
          seq_cnt_d = '0;
          state_d = RPS_OFF;
        end
      end
      default: begin
        state_d = RPS_OFF;
        seq_cnt_d = '0;
        out_d = '0;
      end
    endcase
  end

  // Sequencer registers; reset forces everything to the safe state.
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= RPS_OFF;
      seq_cnt_q <= '0;
      out_q <= '0;
    end else begin
      state_q <= state_d;
      seq_cnt_q <= seq_cnt_d;
      out_q <= out_d;
    end
  end

  // Outputs come straight from flops.
  assign supply_ok_flag_n = out_q.supply_ok_flag_n;
  assign system_run_line = out_q.system_run_line;
  assign clamp_relay_on = out_q.clamp_relay_on;
  assign regulator_inhibit = fault_q;

  // Run line rises exactly the switch-on delay after entering wait.
  property run_rise_p;
    @(posedge clock) disable iff (srst)
      $rose(system_run_line) |-> $past(state_q) == RPS_ON_WAIT
        && $past(seq_cnt_q) == CNT_W'(ON_DELAY - 1);
  endproperty
  run_rise_a: assert property (run_rise_p)
    else $error("Run line rose outside switch-on wait.");

  // Flag only rises while the run line is high.
  flag_rise_a: assert property (
    @(posedge clock) disable iff (srst)
      $rose(supply_ok_flag_n) |-> system_run_line && $past(system_run_line))
    else $error("Flag rose without run line high.");

  // Loss of a condition drops the flag on the next edge.
  flag_drop_a: assert property (
    @(posedge clock) disable iff (srst)
      (supply_ok_flag_n && !(mains_ok_q && level_q[1] && power_switch_on))
      |=> !supply_ok_flag_n)
    else $error("Flag did not drop at switch-off.");

  // Run line stays high for the flag's falling edge and the edge after it.
  run_hold_a: assert property (
    @(posedge clock) disable iff (srst)
      $fell(supply_ok_flag_n) |-> system_run_line [*2])
    else $error("Run line fell too soon after flag.");

  // Run line and relay release together at switch-off.
  relay_drop_a: assert property (
    @(posedge clock) disable iff (srst)
      $fell(system_run_line) |-> !clamp_relay_on)
    else $error("Relay still on after run line fell.");

  // Run high implies the clamp is released.
  clamp_order_a: assert property (
    @(posedge clock) disable iff (srst)
      system_run_line |-> clamp_relay_on)
    else $error("Run line high with clamp applied.");

  // Mains only counts as failed after the full dropout time. The check
  // looks one edge back, since mains may already be back by then.
  mains_qual_a: assert property (
    @(posedge clock) disable iff (srst)
      $fell(mains_ok_q) |-> $past(!level_q[0])
        && $past(drop_cnt_q) == CNT_W'(MAINS_QUAL))
    else $error("Mains failed without a dropout.");

  // The flag is never up while the run line is down.
  flag_run_a: assert property (
    @(posedge clock) disable iff (srst)
      supply_ok_flag_n |-> system_run_line)
    else $error("Flag high while run line low.");

  // The relay is only energised at the clamp point of the switch-on wait.
  relay_rise_a: assert property (
    @(posedge clock) disable iff (srst)
      $rose(clamp_relay_on) |-> $past(state_q) == RPS_ON_WAIT
        && $past(seq_cnt_q) == CNT_W'(CLAMP_DELAY - 1))
    else $error("Relay energised at the wrong time.");

  // Once the off wait starts it only ends by reaching off, run low.
  off_finish_a: assert property (
    @(posedge clock) disable iff (srst)
      state_q == RPS_OFF_WAIT |=> state_q == RPS_OFF_WAIT
        || (state_q == RPS_OFF && !system_run_line))
    else $error("Switch-off sequence was cut short.");

  // A synchronised overcurrent latches the fault on the next edge.
  fault_set_a: assert property (
    @(posedge clock) disable iff (srst)
      level_q[2] |=> regulator_inhibit)
    else $error("Overcurrent did not latch the fault.");

  // Fault, once latched, stays.
  fault_hold_a: assert property (
    @(posedge clock) disable iff (srst)
      regulator_inhibit |=> regulator_inhibit)
    else $error("Overcurrent fault was released.");

  // Reset leaves the flag, run line and relay low.
  reset_safe_a: assert property (
    @(posedge clock) srst |=> !supply_ok_flag_n && !system_run_line
      && !clamp_relay_on)
    else $error("Outputs not safe after reset.");

  power_up_c: cover property (@(posedge clock) disable iff (srst)
    $rose(supply_ok_flag_n));
  power_down_c: cover property (@(posedge clock) disable iff (srst)
    $fell(system_run_line));
  abort_on_c: cover property (@(posedge clock) disable iff (srst)
    state_q == RPS_ON_WAIT ##1 state_q == RPS_OFF);
  // A short dropout ridden through while the supply is up.
  ride_through_c: cover property (@(posedge clock) disable iff (srst)
    !level_q[0] && mains_ok_q && supply_ok_flag_n);
  fault_c: cover property (@(posedge clock) disable iff (srst)
    $rose(regulator_inhibit));

endmodule // rps_sequencer

`default_nettype wire

// ### hw/rps_pkg.sv
package rps_pkg;

  // Clock rate in kilohertz.
  localparam int unsigned CLK_KHZ = 100000;

  // Sequence times in their own units.
  localparam int unsigned MAINS_QUAL_MS = 10;
  localparam int unsigned ON_DELAY_MS = 300;
  localparam int unsigned CLAMP_DELAY_MS = 150;
  localparam int unsigned FLAG_DELAY_US = 400;
  localparam int unsigned RUN_OFF_DELAY_MS = 2;

  // Derived cycle counts; all are whole multiples of the period.
  localparam int unsigned MAINS_QUAL_CYC = MAINS_QUAL_MS * CLK_KHZ;
  localparam int unsigned ON_DELAY_CYC = ON_DELAY_MS * CLK_KHZ;
  localparam int unsigned CLAMP_DELAY_CYC = CLAMP_DELAY_MS * CLK_KHZ;
  localparam int unsigned FLAG_DELAY_CYC = FLAG_DELAY_US * CLK_KHZ / 1000;
  localparam int unsigned RUN_OFF_DELAY_CYC = RUN_OFF_DELAY_MS * CLK_KHZ;

  // Counter width, enough for the longest delay.
  localparam int unsigned CNT_W = 25;

  // Sequencer states.
  typedef enum logic [2:0] {
    RPS_OFF = 3'b000,
    RPS_ON_WAIT = 3'b001,
    RPS_FLAG_WAIT = 3'b010,
    RPS_RUNNING = 3'b011,
    RPS_OFF_WAIT = 3'b100
  } rps_state_t;

  // Qualified supply conditions handed into the sequencer.
  typedef struct packed {
    logic mains_ok;
    logic p5v_ok;
    logic switch_on;
  } rps_cond_t;

  // Outputs of the sequencer, kept together.
  typedef struct packed {
    logic supply_ok_flag_n;
    logic system_run_line;
    logic clamp_relay_on;
  } rps_out_t;

endpackage : rps_pkg

// ### bench/rps_unit_model.sv
`timescale 1ns/1ps
`default_nettype none

// Control units of the rack: they only listen, and stamp each
// change of the flag, run line and relay with the cycle seen.
module rps_unit_model (
  input wire logic clock,
  input wire logic flag_n,
  input wire logic run,
  input wire logic relay,
  output var int cyc,
  output var int t_up[3],
  output var int t_dn[3]
);
  logic [2:0] now_v;
  logic [2:0] last_v = 3'h0;

  assign now_v = {relay, run, flag_n};
  initial cyc = 0;

  // Stamps lag the change by one edge; the bench waits for that.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    last_v <= now_v;
    for (int i = 0; i < 3; i++) begin
      if (now_v[i] === 1'b1 && last_v[i] === 1'b0) begin
        t_up[i] <= cyc;
      end
      if (now_v[i] === 1'b0 && last_v[i] === 1'b1) begin
        t_dn[i] <= cyc;
      end
    end
  end
endmodule // rps_unit_model

`default_nettype wire

// ### bench/tb_rps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module tb_rps_sequencer;
  // Short delays keep the run brief; the gaps stay distinct.
  localparam int QUAL = 5;
  localparam int ON = 40;
  localparam int CLMP = 20;
  localparam int FLG = 4;
  localparam int ROFF = 6;

  logic clock = 1'b0;
  logic srst, mains, p5v, sw, oc;
  logic flag_n, run, relay, inhibit;
  logic [2:0] outs;
  logic [7:0] lfsr_q = 8'h4B;
  int cyc;
  int n_fail = 0;
  int check_count = 0;
  int t_up[3];
  int t_dn[3];

  assign outs = {relay, run, flag_n};

  // Ten nanosecond clock.
  always #5 clock = ~clock;

  rps_sequencer #(
    .MAINS_QUAL(QUAL),
    .ON_DELAY(ON),
    .CLAMP_DELAY(CLMP),
    .FLAG_DELAY(FLG),
    .RUN_OFF_DELAY(ROFF)
  ) i_rps_sequencer (
    .clock(clock),
    .srst(srst),
    .mains_present(mains),
    .p5v_present(p5v),
    .power_switch_on(sw),
    .overcurrent(oc),
    .supply_ok_flag_n(flag_n),
    .system_run_line(run),
    .clamp_relay_on(relay),
    .regulator_inhibit(inhibit)
  );

  rps_unit_model i_rps_unit_model (
    .clock(clock),
    .flag_n(flag_n),
    .run(run),
    .relay(relay),
    .cyc(cyc),
    .t_up(t_up),
    .t_dn(t_dn)
  );

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Earliest flag drop per cause; the two synced inputs lag more.
  function automatic int lat_lo(input int c);
    return c == 2 ? 1 : (c == 1 ? 2 : QUAL + 1);
  endfunction

  // Inputs move just after the edge, never on it.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic chk_rng(input string n, input int lo, input int hi,
                         input int g);
    check_count++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("ERROR %s exp %0d..%0d got %0d", n, lo, hi, g);
    end
  endtask

  // Bounded wait for one output; running out ends the run.
  task automatic wait_v(input int i, input logic v);
    int k;
    k = 0;
    while (outs[i] !== v && k < 2000) begin
      tick(1);
      k++;
    end
    if (k >= 2000) begin
      chk_bit("wait_timeout", v, outs[i]);
      summarize();
    end
  endtask

  task automatic power_on();
    int t0;
    sw = 1'b1;
    t0 = cyc;
    wait_v(2, 1'b1);
    chk_bit("run_at_clamp", 1'b0, run);
    wait_v(1, 1'b1);
    chk_rng("on_delay", ON, ON + 3, cyc - t0);
    wait_v(0, 1'b1);
    tick(1);
    chk_rng("clamp_gap", ON - CLMP, ON - CLMP, t_up[1] - t_up[2]);
    chk_rng("flag_gap", FLG, FLG, t_up[0] - t_up[1]);
  endtask

  // Cause 0 is mains, 1 is the 5V output, 2 is the switch.
  task automatic power_off(input int c);
    int t0;
    t0 = cyc;
    if (c == 0) mains = 1'b0;
    else if (c == 1) p5v = 1'b0;
    else sw = 1'b0;
    wait_v(0, 1'b0);
    chk_rng("off_lat", lat_lo(c), lat_lo(c) + 8, cyc - t0);
    // Mains comes back at once, yet the sequence must finish.
    mains = 1'b1;
    chk_bit("run_held", 1'b1, run);
    wait_v(1, 1'b0);
    tick(1);
    chk_rng("run_off", ROFF, ROFF, t_dn[1] - t_dn[0]);
    chk_rng("relay_off", 0, 0, t_dn[2] - t_dn[1]);
    chk_bit("off_done", 1'b0, run);
    chk_bit("relay_low", 1'b0, relay);
    sw = 1'b0;
    p5v = 1'b1;
    tick(20);
  endtask

  task automatic summarize();
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    srst = 1'b1;
    mains = 1'b1;
    p5v = 1'b1;
    sw = 1'b0;
    oc = 1'b0;
    tick(12);
    chk_bit("reset_out", 1'b0, |{outs, inhibit});
    srst = 1'b0;
    tick(20);
    // Switch off while the switch-on delay still runs.
    sw = 1'b1;
    tick(CLMP + 8);
    sw = 1'b0;
    tick(ON + 10);
    chk_bit("abort_out", 1'b0, |outs);
    power_on();
    // Dropouts shorter than the qualify time, longest first.
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      mains = 1'b0;
      tick(i == 0 ? QUAL - 1 : 1 + lfsr_q % (QUAL - 1));
      mains = 1'b1;
      tick(12);
      chk_bit("dropout_flag", 1'b1, flag_n);
    end
    for (int i = 0; i < 6; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      power_off(i < 3 ? i : lfsr_q % 3);
      power_on();
    end
    chk_bit("oc_idle", 1'b0, inhibit);
    oc = 1'b1;
    tick(2);
    oc = 1'b0;
    tick(10);
    chk_bit("oc_latch", 1'b1, inhibit);
    srst = 1'b1;
    tick(2);
    chk_bit("mid_reset", 1'b0, |{outs, inhibit});
    // Release again with the switch off, then power up from cold.
    sw = 1'b0;
    srst = 1'b0;
    tick(20);
    chk_bit("release_out", 1'b0, |{outs, inhibit});
    power_on();
    summarize();
  end
endmodule // tb_rps_sequencer

`default_nettype wire
